// >>> iep_cfg.svh
// Constants of the interrupt enable and protect control block
// Behaviour
// - The misc instruction violation is the AND of class-B decode, delta zero, guard flag and protect switch.
// - Only that transform-level violation is flagged here; all other cases belong elsewhere.
// - After the enable-interrupt, a register-type instruction sets interrupt-enabled at the next read-next cycle.
// - After the enable-interrupt, a storage or enhanced instruction sets it only at the end-of-emulation increment.
// - The end-of-emulation increment is micro bits 2..5 equal to 1011 with the gate clock.
// - Setting interrupt-enabled clears the pre-enable bit in hardware; here a CTRL write of pre-enable 1 in the same cycle keeps it set.
// - The inhibit-or-false output goes low for instruction 0500 hex or a false-interrupt flag of 1.
// - Normally the destination-strobe permit is set high at phase T3 so the T4 strobe may occur.
// - While the gated transform strobe is low the permit is held low.
// - A fetch-and-transform of a storage or enhanced instruction drives the halt-interrupt block low.
// - The end-of-emulation increment returns the halt-interrupt block high.
// - The delayed master clear forces the halt-interrupt block high.
// - A fetch-and-transform sets the fault-detect enable bit at the gate clock edge.
`ifndef IEP_CFG_SVH
`define IEP_CFG_SVH
`define IEP_AW          8
`define IEP_OFS_CTRL    8'h00
`define IEP_OFS_STATUS  8'h04
`define IEP_OFS_IRQ_ST  8'h08
`define IEP_OFS_IRQ_MSK 8'h0c
`define IEP_CTRL_PRE    0
`define IEP_CTRL_IE     1
`define IEP_CTRL_FDE    2
`define IEP_IRQ_W       3
`define IEP_IRQ_VIOL    0
`define IEP_IRQ_IE      1
`define IEP_IRQ_HIB     2
`define IEP_OP_INHIBIT  16'h0500
`define IEP_SUBFN_CLASS_B 4'hb
`define IEP_SUBINC_CODE 4'hb
`define IEP_RST_HIB     1'b1
`define IEP_RST_INH_N   1'b1
`define IEP_SYNC_STAGES 3
`endif

// >>> iep_pkg.sv
// Types of the interrupt enable and protect control block
package iep_pkg;
   typedef enum logic [1:0] {
      IEP_SQ_IDLE = 2'b00,
      IEP_SQ_WAIT = 2'b01
   } iep_seq_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq;
      logic        pre_en;
      logic        ie;
      logic        fde;
      logic        viol;
      logic        inh_n;
      logic        dsp;
      logic        hib;
      iep_seq_t    seq;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic        prev_gate;
      logic        prev_t3;
   } iep_state_t;
endpackage : iep_pkg

// >>> iep_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module iep_sync #(
   parameter int W = 8
) (
   input  wire logic         CLOCK,
   input  wire logic         SRST,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] filt;
   } iep_sync_st_t;

   iep_sync_st_t st_r;
   iep_sync_st_t st_nxt;

   // Stage one feeds stage two only; filter looks at two and three
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.filt[i] = st_r.s2[i];
         end
      end
   end

   // Registered state
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.filt;
endmodule : iep_sync

// >>> iep_ctl.sv
// Interrupt enable sequencing, protect violation and strobe block logic
`timescale 1ns/1ps
`include "iep_cfg.svh"
module iep_ctl (
   input  wire logic                CLOCK,
   input  wire logic                SRST,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [`IEP_AW-1:0]  PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic                     PREADY,
   output logic      [31:0]         PRDATA,
   output logic                     PSLVERR,
   output logic                     IRQ,
   input  wire logic                TRANSFORM_SELECT,
   input  wire logic                MICRO_REGISTER_GATE_CLOCK,
   input  wire logic                PHASE_T3,
   input  wire logic                GATED_TRANSFORM_STROBE_N,
   input  wire logic                DELAYED_MASTER_CLEAR_N,
   input  wire logic                MACRO_FETCH_TRANSFORM,
   input  wire logic                ENHANCED_INSTR,
   input  wire logic                MEMORY_GUARD_FLAG,
   input  wire logic                PROTECT_SWITCH,
   input  wire logic                FALSE_INTERRUPT_FLAG,
   input  wire logic [15:0]         INSTR,
   input  wire logic [3:0]          MICRO_BITS,
   output logic                     MISC_INSTR_VIOLATION,
   output logic                     INHIBIT_OR_FALSE_N,
   output logic                     DEST_STROBE_PERMIT,
   output logic                     HALT_INTERRUPT_BLOCK,
   output logic                     INTERRUPT_PRE_ENABLE_BIT,
   output logic                     INTERRUPT_ENABLED_BIT,
   output logic                     FAULT_DETECT_ENABLE
);
   localparam int SW = 30;

   localparam iep_pkg::iep_state_t ST_RST = '{
      pready:   1'b0,
      prdata:   32'h0000_0000,
      pslverr:  1'b0,
      irq:      1'b0,
      pre_en:   1'b0,
      ie:       1'b0,
      fde:      1'b0,
      viol:     1'b0,
      inh_n:    `IEP_RST_INH_N,
      dsp:      1'b0,
      hib:      `IEP_RST_HIB,
      seq:      iep_pkg::IEP_SQ_IDLE,
      irq_stat: 3'h0,
      irq_mask: 3'h0,
      prev_gate: 1'b0,
      prev_t3:  1'b0
   };

   iep_pkg::iep_state_t st_r;
   iep_pkg::iep_state_t st_nxt;

   logic [SW-1:0] raw;
   logic [SW-1:0] syn;
   logic          s_xsel;
   logic          s_gate;
   logic          s_t3;
   logic          s_gxt_n;
   logic          s_mclr_n;
   logic          s_mft;
   logic          s_enh;
   logic          s_mg;
   logic          s_ps;
   logic          s_false;
   logic [15:0]   s_instr;
   logic [3:0]    s_mb;
   logic          gate_ev;
   logic          t3_ev;
   logic          f_zero;
   logic          d_zero;
   logic          subfn_b;
   logic          class_b;
   logic          rr_cond;
   logic          mem_or_enh;
   logic          xg;
   logic          sub_inc;
   logic          set_now;
   logic          set_late;
   logic          ie_set;
   logic          setup;
   logic          wr_acc;
   logic          wr_ctrl;
   logic          wr_ist;
   logic          wr_msk;

   // All control pins except the APB bus cross in through the three-stage filter
   assign raw = {TRANSFORM_SELECT, MICRO_REGISTER_GATE_CLOCK, PHASE_T3,
                 GATED_TRANSFORM_STROBE_N, DELAYED_MASTER_CLEAR_N,
                 MACRO_FETCH_TRANSFORM, ENHANCED_INSTR, MEMORY_GUARD_FLAG,
                 PROTECT_SWITCH, FALSE_INTERRUPT_FLAG, INSTR, MICRO_BITS};

   iep_sync #(
      .W    (SW)
   ) u_sync (
      .CLOCK (CLOCK),
      .SRST  (SRST),
      .din   (raw),
      .dout  (syn)
   );

   assign {s_xsel, s_gate, s_t3, s_gxt_n, s_mclr_n, s_mft, s_enh, s_mg,
           s_ps, s_false, s_instr, s_mb} = syn;

   // Phase events; the hardware enable set, fetch decode and T3 permit set move only on these
   assign gate_ev = s_gate & ~st_r.prev_gate;
   assign t3_ev   = s_t3 & ~st_r.prev_t3;

   // Instruction field decode
   assign f_zero     = (s_instr[15:12] == 4'h0);
   assign d_zero     = (s_instr[7:0] == 8'h00);
   assign subfn_b    = (s_instr[11:8] == `IEP_SUBFN_CLASS_B);
   assign class_b    = f_zero & subfn_b;
   // Enhanced instructions always take the late path, whatever their fields
   assign rr_cond    = f_zero & ~s_enh & (s_instr[4] | ~s_instr[5] | ~d_zero)
                       & (subfn_b | ~d_zero);
   assign mem_or_enh = ~f_zero | s_enh;
   assign xg         = s_xsel & gate_ev;

   // End-of-emulation increment decode
   assign sub_inc = (s_mb == `IEP_SUBINC_CODE) & gate_ev;

   // Pre-enable arms both paths; firmware sets it
   assign set_now  = st_r.pre_en & xg & rr_cond;
   assign set_late = (st_r.seq == iep_pkg::IEP_SQ_WAIT) & sub_inc;
   assign ie_set   = set_now | set_late;

   // Bus phase decode
   assign setup   = PSEL & ~PENABLE;
   assign wr_acc  = PSEL & PENABLE & PWRITE & st_r.pready;
   assign wr_ctrl = wr_acc & (PADDR == `IEP_OFS_CTRL);
   assign wr_ist  = wr_acc & (PADDR == `IEP_OFS_IRQ_ST);
   assign wr_msk  = wr_acc & (PADDR == `IEP_OFS_IRQ_MSK);

   // Next-state logic for the whole block
   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.prev_gate = s_gate;
      st_nxt.prev_t3   = s_t3;

      // Software writes first so hardware sets win a collision
      if (wr_ctrl)
      begin
         st_nxt.pre_en = PWDATA[`IEP_CTRL_PRE];
         st_nxt.ie     = PWDATA[`IEP_CTRL_IE];
         st_nxt.fde    = PWDATA[`IEP_CTRL_FDE];
      end
      if (wr_msk)
      begin
         st_nxt.irq_mask = PWDATA[`IEP_IRQ_W-1:0];
      end

      // Enable sequencing; a fresh firmware arm beats the clear
      if (ie_set)
      begin
         st_nxt.ie = 1'b1;
         if (!(wr_ctrl && PWDATA[`IEP_CTRL_PRE]))
         begin
            st_nxt.pre_en = 1'b0;
         end
      end
      case (st_r.seq)
         iep_pkg::IEP_SQ_IDLE:
         begin
            if (st_r.pre_en && xg && !rr_cond)
            begin
               st_nxt.seq = iep_pkg::IEP_SQ_WAIT;
            end
         end
         iep_pkg::IEP_SQ_WAIT:
         begin
            if (sub_inc || !st_nxt.pre_en)
            begin
               st_nxt.seq = iep_pkg::IEP_SQ_IDLE;
            end
         end
         default:
         begin
            st_nxt.seq = iep_pkg::IEP_SQ_IDLE;
         end
      endcase

      // Fault detection armed by every fetch-and-transform
      if (gate_ev && s_mft)
      begin
         st_nxt.fde = 1'b1;
      end

      // Only the misc class is judged here
      st_nxt.viol  = class_b & d_zero & s_mg & s_ps;
      st_nxt.inh_n = ~((s_instr == `IEP_OP_INHIBIT) | s_false);

      // Gated strobe low overrides the T3 set
      if (!s_gxt_n)
      begin
         st_nxt.dsp = 1'b0;
      end
      else if (t3_ev)
      begin
         st_nxt.dsp = 1'b1;
      end

      // Clear and end of emulation both release the block
      if (!s_mclr_n)
      begin
         st_nxt.hib = 1'b1;
      end
      else if (sub_inc)
      begin
         st_nxt.hib = 1'b1;
      end
      else if (xg && s_mft && mem_or_enh)
      begin
         st_nxt.hib = 1'b0;
      end

      // Sticky events, clear by one, set beats clear
      if (wr_ist)
      begin
         st_nxt.irq_stat = st_r.irq_stat & ~PWDATA[`IEP_IRQ_W-1:0];
      end
      if (st_nxt.viol && !st_r.viol)
      begin
         st_nxt.irq_stat[`IEP_IRQ_VIOL] = 1'b1;
      end
      if (ie_set)
      begin
         st_nxt.irq_stat[`IEP_IRQ_IE] = 1'b1;
      end
      if (!st_nxt.hib && st_r.hib)
      begin
         st_nxt.irq_stat[`IEP_IRQ_HIB] = 1'b1;
      end
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

      // Zero-wait slave: answer prepared in the setup cycle
      st_nxt.pready  = setup;
      st_nxt.prdata  = 32'h0000_0000;
      st_nxt.pslverr = 1'b0;
      if (setup)
      begin
         if (PADDR == `IEP_OFS_CTRL)
         begin
            st_nxt.prdata[`IEP_CTRL_PRE] = st_r.pre_en;
            st_nxt.prdata[`IEP_CTRL_IE]  = st_r.ie;
            st_nxt.prdata[`IEP_CTRL_FDE] = st_r.fde;
         end
         else if (PADDR == `IEP_OFS_STATUS)
         begin
            st_nxt.prdata[5:0] = {st_r.seq == iep_pkg::IEP_SQ_WAIT, st_r.hib,
                                  st_r.dsp, st_r.inh_n, st_r.viol, st_r.irq};
         end
         else if (PADDR == `IEP_OFS_IRQ_ST)
         begin
            st_nxt.prdata[`IEP_IRQ_W-1:0] = st_r.irq_stat;
         end
         else if (PADDR == `IEP_OFS_IRQ_MSK)
         begin
            st_nxt.prdata[`IEP_IRQ_W-1:0] = st_r.irq_mask;
         end
         else
         begin
            st_nxt.pslverr = 1'b1;                         // Unmapped answers error
         end
      end
   end

   // Single state register
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         st_r <= ST_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Every output straight from the state register
   assign PREADY                   = st_r.pready;
   assign PRDATA                   = st_r.prdata;
   assign PSLVERR                  = st_r.pslverr;
   assign IRQ                      = st_r.irq;
   assign MISC_INSTR_VIOLATION     = st_r.viol;
   assign INHIBIT_OR_FALSE_N       = st_r.inh_n;
   assign DEST_STROBE_PERMIT       = st_r.dsp;
   assign HALT_INTERRUPT_BLOCK     = st_r.hib;
   assign INTERRUPT_PRE_ENABLE_BIT = st_r.pre_en;
   assign INTERRUPT_ENABLED_BIT    = st_r.ie;
   assign FAULT_DETECT_ENABLE      = st_r.fde;

   // Checks on the block's own behaviour
   a_viol_gate: assert property (
      @(posedge CLOCK) disable iff (SRST)
      MISC_INSTR_VIOLATION |-> $past(s_mg) && $past(s_ps) && $past(d_zero))
      else $error("violation without guard, switch and zero delta");

   a_viol_class: assert property (
      @(posedge CLOCK) disable iff (SRST)
      !$past(class_b) |-> !MISC_INSTR_VIOLATION)
      else $error("violation flagged outside the misc class");

   a_ie_now: assert property (
      @(posedge CLOCK) disable iff (SRST)
      set_now |=> INTERRUPT_ENABLED_BIT && st_r.irq_stat[`IEP_IRQ_IE])
      else $error("register-type follow-up did not enable interrupts");

   a_ie_late: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (st_r.pre_en && xg && !rr_cond && st_r.seq == iep_pkg::IEP_SQ_IDLE)
      |=> !set_now throughout (st_r.seq == iep_pkg::IEP_SQ_WAIT)[*1])
      else $error("storage follow-up did not wait for the increment");

   a_inc_decode: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (st_r.seq == iep_pkg::IEP_SQ_WAIT && s_mb != `IEP_SUBINC_CODE && st_r.pre_en
       && !(wr_ctrl && !PWDATA[`IEP_CTRL_PRE])) |=> st_r.seq == iep_pkg::IEP_SQ_WAIT)
      else $error("wrong micro code ended the wait");

   a_pre_clear: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (ie_set && !(wr_ctrl && PWDATA[`IEP_CTRL_PRE])) |=> !INTERRUPT_PRE_ENABLE_BIT)
      else $error("pre-enable survived the enable");

   a_inh_low: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (s_false || s_instr == `IEP_OP_INHIBIT) |=> !INHIBIT_OR_FALSE_N)
      else $error("inhibit or false interrupt not signalled");

   a_dsp_t3: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (t3_ev && s_gxt_n) |=> DEST_STROBE_PERMIT)
      else $error("permit not raised at T3");

   a_dsp_block: assert property (
      @(posedge CLOCK) disable iff (SRST)
      !s_gxt_n ##1 !s_gxt_n |-> !DEST_STROBE_PERMIT ##1 !DEST_STROBE_PERMIT)
      else $error("permit high while gated strobe low");

   a_hib_low: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (xg && s_mft && mem_or_enh && !sub_inc && s_mclr_n) |=> !HALT_INTERRUPT_BLOCK)
      else $error("halt block not asserted on fetch");

   a_hib_end: assert property (
      @(posedge CLOCK) disable iff (SRST)
      sub_inc |=> HALT_INTERRUPT_BLOCK)
      else $error("halt block not released by increment");

   a_hib_clear: assert property (
      @(posedge CLOCK) disable iff (SRST)
      $fell(s_mclr_n) |=> HALT_INTERRUPT_BLOCK)
      else $error("halt block not forced by master clear");

   a_fde_set: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (gate_ev && s_mft) |=> FAULT_DETECT_ENABLE)
      else $error("fault detect not set on fetch");

   a_ie_event: assert property (
      @(posedge CLOCK) disable iff (SRST)
      $rose(INTERRUPT_ENABLED_BIT) |-> $past(gate_ev) || $past(wr_ctrl))
      else $error("enable moved without a gate event");

   a_irq_level: assert property (
      @(posedge CLOCK) disable iff (SRST)
      IRQ == |(st_r.irq_stat & st_r.irq_mask))
      else $error("interrupt output disagrees with status and mask");

   a_apb_ready: assert property (
      @(posedge CLOCK) disable iff (SRST)
      setup |=> PREADY ##1 !PREADY)
      else $error("bus answer not one cycle after setup");

endmodule : iep_ctl

// >>> iep_host.sv
// Host processor model: micro-register gate clock pulses and T3 phase
`timescale 1ns/1ps
module iep_host (
   input  wire logic CLOCK,
   input  wire logic SRST,
   input  wire logic gate_req,
   output logic      gate_busy,
   output logic      gate_clk,
   output logic      phase_t3
);
   logic [3:0] t3_cnt_r;
   logic [3:0] g_cnt_r;

   // T3 runs free, five cycles high and low so the pin filter sees each edge
   always_ff @(posedge CLOCK)
   begin
      if (SRST || t3_cnt_r == 4'h9)
         t3_cnt_r <= 4'h0;
      else
         t3_cnt_r <= t3_cnt_r + 4'h1;
   end

   // Gate pulse: four cycles of data setup, five high, six low
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
         g_cnt_r <= 4'h0;
      else if (g_cnt_r != 4'h0 || gate_req)
         g_cnt_r <= g_cnt_r + 4'h1;
   end

   // Phase and gate pulses decoded from the free-running and gate counters
   assign phase_t3  = (t3_cnt_r >= 4'h5);
   assign gate_clk  = (g_cnt_r >= 4'h5) && (g_cnt_r <= 4'h9);
   assign gate_busy = (g_cnt_r != 4'h0);
endmodule : iep_host

// >>> tb_interrupt_enable_protect_ctl.sv
// Self-checking bench of the interrupt enable and protect control block
`timescale 1ns/1ps
`include "iep_cfg.svh"
module tb_interrupt_enable_protect_ctl;
   logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        tsel, gclk, t3, gts_n, mclr_n, fetch, enh, guard, prot, fls;
   logic [15:0] instr;
   logic [3:0]  mbits;
   logic        viol, inh_n, dsp, hib, pre, ie, fde, greq, gbusy, ev, ei;
   int          n_errors, check_count;
   logic [31:0] rdat;
   logic        rerr;
   wire  [7:0]  obs = {irq, fde, ie, pre, hib, dsp, inh_n, viol};
   // Rows: instr, guard, protect, false flag, violation, inhibit_n
   localparam logic [20:0] ROWS [9] = '{
      {16'h0b00, 5'h1b}, {16'h0b00, 5'h09}, {16'h0b00, 5'h11},
      {16'h0b01, 5'h19}, {16'h1b00, 5'h19}, {16'h0a00, 5'h19},
      {16'h0500, 5'h00}, {16'h0501, 5'h01}, {16'h0b00, 5'h1e}};

   iep_ctl DUT (.CLOCK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq), .TRANSFORM_SELECT(tsel),
      .MICRO_REGISTER_GATE_CLOCK(gclk), .PHASE_T3(t3),
      .GATED_TRANSFORM_STROBE_N(gts_n), .DELAYED_MASTER_CLEAR_N(mclr_n),
      .MACRO_FETCH_TRANSFORM(fetch), .ENHANCED_INSTR(enh),
      .MEMORY_GUARD_FLAG(guard), .PROTECT_SWITCH(prot),
      .FALSE_INTERRUPT_FLAG(fls), .INSTR(instr), .MICRO_BITS(mbits),
      .MISC_INSTR_VIOLATION(viol), .INHIBIT_OR_FALSE_N(inh_n),
      .DEST_STROBE_PERMIT(dsp), .HALT_INTERRUPT_BLOCK(hib),
      .INTERRUPT_PRE_ENABLE_BIT(pre), .INTERRUPT_ENABLED_BIT(ie),
      .FAULT_DETECT_ENABLE(fde));

   iep_host u_host (.CLOCK(clk), .SRST(srst), .gate_req(greq),
      .gate_busy(gbusy), .gate_clk(gclk), .phase_t3(t3));

   // Clock at 250 MHz
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task end_sim();
      $display("Checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One APB transfer; idles one cycle after so no signal is driven twice at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic er);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
         chk("pready", 32'h1, 32'h0);
      r = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk("write pslverr", 32'h0, {31'h0, e});
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input string nm);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, x, r & m);
   endtask : rd

   // Bounded wait for one observed output to reach a level
   task wait_bit(input int i, input logic e, input string nm);
      int n;
      n = 0;
      while (obs[i] !== e && n < 24)
      begin
         @(posedge clk);
         n++;
      end
      chk(nm, {31'h0, e}, {31'h0, obs[i]});
   endtask : wait_bit

   // Gate pulse from the host model; data pins must already be set
   task gate();
      greq <= 1'b1;
      @(posedge clk);
      greq <= 1'b0;
      @(posedge clk);
      while (gbusy)
         @(posedge clk);
      repeat (2) @(posedge clk);
   endtask : gate

   // Watchdog: the whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, greq} = '0;
      {tsel, fetch, enh, guard, prot, fls, instr, mbits} = '0;
      gts_n = 1'b1;
      mclr_n = 1'b1;
      srst = 1'b1;
      n_errors = 0;
      check_count = 0;
      repeat (20) @(posedge clk);
      chk("reset outputs", 32'h0a, {24'h0, obs});
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`IEP_OFS_CTRL, 32'h0, 32'h7, "ctrl reset");
      rd(`IEP_OFS_IRQ_MSK, 32'h0, 32'h7, "mask reset");
      rd(8'h10, 32'h0, 32'hffffffff, "unmapped read");
      // Unmapped access must answer with an error and no data
      apb(1'b1, 8'h10, 32'hffff_ffff, rdat, rerr);
      chk("unmapped pslverr", 32'h1, {31'h0, rerr});
      chk("unmapped prdata", 32'h0, rdat);
      // Combinational decode table
      for (int k = 0; k < 9; k++)
      begin
         {instr, guard, prot, fls, ev, ei} <= ROWS[k];
         repeat (10) @(posedge clk);
         chk("violation", {31'h0, ev}, {31'h0, viol});
         chk("inhibit_n", {31'h0, ei}, {31'h0, inh_n});
      end
      {guard, prot, fls} <= 3'h0;
      // Strobe permit is set by T3 unless the gated strobe is low
      wait_bit(2, 1'b1, "permit");
      gts_n <= 1'b0;
      wait_bit(2, 1'b0, "permit blocked");
      repeat (20) @(posedge clk);
      chk("permit held", 32'h0, {31'h0, dsp});
      gts_n <= 1'b1;
      wait_bit(2, 1'b1, "permit back");
      // Register-type instruction after enable
      wr(`IEP_OFS_CTRL, 32'h1);
      rd(`IEP_OFS_CTRL, 32'h1, 32'h7, "ctrl pre");
      tsel <= 1'b1;
      instr <= 16'h0b00;
      gate();
      chk("enabled reg", 32'h1, {31'h0, ie});
      chk("pre cleared", 32'h0, {31'h0, pre});
      chk("fde no fetch", 32'h0, {31'h0, fde});
      rd(`IEP_OFS_IRQ_ST, 32'h2, 32'h2, "stat enabled");
      // Storage then enhanced instruction: wait for the increment decode
      for (int k = 0; k < 2; k++)
      begin
         wr(`IEP_OFS_CTRL, 32'h0);
         wr(`IEP_OFS_CTRL, 32'h1);
         tsel  <= 1'b1;
         fetch <= 1'b1;
         instr <= (k == 0) ? 16'h1000 : 16'h0b00;
         enh   <= (k == 1);
         mbits <= 4'h0;
         gate();
         chk("enabled early", 32'h0, {31'h0, ie});
         chk("halt blocked", 32'h0, {31'h0, hib});
         chk("fde set", 32'h1, {31'h0, fde});
         rd(`IEP_OFS_STATUS, 32'h20, 32'h20, "status waiting");
         tsel  <= 1'b0;
         fetch <= 1'b0;
         mbits <= 4'ha;
         gate();
         chk("near increment", 32'h0, {31'h0, ie});
         mbits <= 4'hb;
         gate();
         chk("enabled incr", 32'h1, {31'h0, ie});
         chk("pre cleared", 32'h0, {31'h0, pre});
         chk("halt released", 32'h1, {31'h0, hib});
         enh <= 1'b0;
      end
      // Halt block interrupt, mask and clear, then master clear
      wr(`IEP_OFS_IRQ_ST, 32'h7);
      tsel  <= 1'b1;
      fetch <= 1'b1;
      instr <= 16'h1000;
      mbits <= 4'h0;
      gate();
      rd(`IEP_OFS_IRQ_ST, 32'h4, 32'h7, "stat halt fell");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`IEP_OFS_IRQ_MSK, 32'h4);
      wait_bit(7, 1'b1, "irq raised");
      wr(`IEP_OFS_IRQ_ST, 32'h4);
      wait_bit(7, 1'b0, "irq cleared");
      tsel  <= 1'b0;
      fetch <= 1'b0;
      mclr_n <= 1'b0;
      wait_bit(3, 1'b1, "halt on clear");
      mclr_n <= 1'b1;
      repeat (8) @(posedge clk);
      end_sim();
   end
endmodule : tb_interrupt_enable_protect_ctl
